// ---- hdl/rltcm_timer.sv ----
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rltcm_timer
    import rltcm_pkg::*;
(
    input wire logic sys_clk, // 40 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic timerInPin, // timer input pin, asynchronous
    input wire logic cmpOut, // analog comparator output, asynchronous
    output logic timerOut, // timer output level
    output logic timerOutEn, // timer output alternate function enabled
    output logic reloadPulse // one-cycle pulse at each reload
);
    ////////////////////////////////////////////////////////////////////////
    // state
    rltcm_ctrl_t ctrl_q, ctrl_d; // control register
    logic [15:0] count_q, count_d; // live count
    logic [15:0] reload_q, reload_d; // reload value
    logic [6:0] pre_q, pre_d; // prescale counter
    logic match_q, match_d; // count equalled reload last edge
    logic reloadGo; // reload action applied at this edge
    logic outLvl_q, outLvl_d; // lasting output level
    logic pulse_q, pulse_d; // one-shot single-cycle inversion
    logic rel_q, rel_d; // reload pulse output
    logic reloaded_q, reloaded_d; // sticky reload seen, for status
    logic [2:0] tinSync_q, tinSync_d; // input sync plus history
    logic [2:0] cmpSync_q, cmpSync_d; // comparator sync plus history
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d; // captured halves
    logic [7:0] awAddr_q, awAddr_d; // captured write address
    logic [31:0] wData_q, wData_d; // captured write data
    logic [3:0] wStrb_q, wStrb_d; // captured strobes
    logic bvalid_q, bvalid_d; // write response pending
    logic [1:0] bresp_q, bresp_d; // write response code
    logic rvalid_q, rvalid_d; // read data pending
    logic [31:0] rdata_q, rdata_d; // read data
    logic [1:0] rresp_q, rresp_d; // read response code

    // byte-lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // true for the edge picked by the polarity bit
    function automatic logic edgeSeen(input logic [2:0] h, input logic pol);
        edgeSeen = pol ? (h[1] & ~h[2]) : (~h[1] & h[2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus and timer next-state logic
    always_comb begin
        logic wrGo;
        logic tick;
        logic isTimed;
        logic [15:0] nextCnt;
        wrGo = 1'b0;
        tick = 1'b0;
        isTimed = 1'b0;
        nextCnt = 16'h0000;
        reloadGo = 1'b0;
        ctrl_d = ctrl_q;
        count_d = count_q;
        reload_d = reload_q;
        pre_d = pre_q;
        match_d = 1'b0;
        outLvl_d = outLvl_q;
        pulse_d = 1'b0;
        rel_d = 1'b0;
        reloaded_d = reloaded_q;
        // only the second stage and history are read by logic
        tinSync_d = {tinSync_q[1:0], timerInPin};
        cmpSync_d = {cmpSync_q[1:0], cmpOut};
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;

        // address and data may arrive in either order
        if (s_axi_awvalid && !awHeld_q && !bvalid_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_q && !bvalid_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        wrGo = awHeld_q && wHeld_q && !bvalid_q;

        // prescaler only in timed modes; counter modes use edges
        isTimed = (ctrl_q.mode == MODE_ONESHOT) || (ctrl_q.mode == MODE_CONT);
        if (ctrl_q.enable) begin
            if (isTimed) begin
                if (pre_q == ctrl_q.preMinus1) begin
                    pre_d = 7'h00;
                    tick = 1'b1;
                end else begin
                    pre_d = pre_q + 7'h01;
                end
            end else if (!match_q && ctrl_q.mode == MODE_COUNTER) begin
                tick = edgeSeen(tinSync_q, ctrl_q.outputPolarityBit);
            end else if (!match_q) begin
                tick = edgeSeen(cmpSync_q, ctrl_q.outputPolarityBit);
            end
        end
        // timed modes spend one more tick on the reload itself, so a pass
        // lasts reload ticks; counter modes reload on the next edge
        reloadGo = match_q && ctrl_q.enable && (!isTimed || tick);

        // equality seen this edge, reload at the next tick in timed modes, at the next edge in counter modes
        if (reloadGo) begin
            count_d = COUNT_RESTART;
            rel_d = 1'b1;
            reloaded_d = 1'b1;
            pre_d = 7'h00;
            if (ctrl_q.mode == MODE_ONESHOT) begin
                ctrl_d.enable = 1'b0;
                pulse_d = 1'b1;
            end else begin
                outLvl_d = ~outLvl_q;
            end
        end else if (tick) begin
            nextCnt = count_q + 16'h0001; // wraps FFFF to 0000
            count_d = nextCnt;
            match_d = (nextCnt == reload_q);
        end else if (match_q && ctrl_q.enable) begin
            // timed modes hold the match until the next prescale tick
            match_d = 1'b1;
        end

        // one-shot level follows polarity bit between pulses
        if (ctrl_q.mode == MODE_ONESHOT) begin
            outLvl_d = ctrl_q.outputPolarityBit;
        end

        // register writes; reloads above lose to a software write, except a status clear
        if (wrGo) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = AXI_OKAY;
            unique case (awAddr_q)
                CTRL_OFS: begin
                    if (wStrb_q[0]) begin
                        ctrl_d.enable = wData_q[CTRL_EN_BIT];
                        ctrl_d.outputPolarityBit = wData_q[CTRL_POL_BIT];
                        ctrl_d.outEn = wData_q[CTRL_OUTEN_BIT];
                        ctrl_d.mode = rltcm_mode_t'(wData_q[CTRL_MODE_LSB +: 2]);
                        // disabled setup also sets the start level
                        if (!ctrl_q.enable) begin
                            outLvl_d = wData_q[CTRL_POL_BIT];
                            pre_d = 7'h00;
                        end
                    end
                    if (wStrb_q[1]) begin
                        ctrl_d.preMinus1 = wData_q[CTRL_PRE_LSB +: 7];
                    end
                end
                COUNT_OFS: begin
                    count_d = merge16(count_q, wData_q, wStrb_q);
                    match_d = 1'b0;
                end
                RELOAD_OFS: reload_d = merge16(reload_q, wData_q, wStrb_q);
                STATUS_OFS: begin
                    // write one clears; a reload in this cycle wins
                    if (wStrb_q[0] && wData_q[0] && !reloadGo) begin
                        reloaded_d = 1'b0;
                    end
                end
                default: bresp_d = AXI_SLVERR;
            endcase
        end

        // read channel
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = AXI_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFS: rdata_d = {17'h0_0000, ctrl_q.preMinus1, 2'b00,
                                     ctrl_q.mode, 1'b0, ctrl_q.outEn,
                                     ctrl_q.outputPolarityBit, ctrl_q.enable};
                COUNT_OFS: rdata_d = {16'h0000, count_q};
                RELOAD_OFS: rdata_d = {16'h0000, reload_q};
                STATUS_OFS: rdata_d = {30'h0000_0000, timerOut, reloaded_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = AXI_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= '{PRE_RESET, MODE_ONESHOT, 1'b0, 1'b0, 1'b0};
            count_q <= COUNT_RESET;
            reload_q <= RELOAD_RESET;
            pre_q <= 7'h00;
            match_q <= 1'b0;
            outLvl_q <= 1'b0;
            pulse_q <= 1'b0;
            rel_q <= 1'b0;
            reloaded_q <= 1'b0;
            tinSync_q <= 3'b000;
            cmpSync_q <= 3'b000;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= AXI_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= AXI_OKAY;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            reload_q <= reload_d;
            pre_q <= pre_d;
            match_q <= match_d;
            outLvl_q <= outLvl_d;
            pulse_q <= pulse_d;
            rel_q <= rel_d;
            reloaded_q <= reloaded_d;
            tinSync_q <= tinSync_d;
            cmpSync_q <= cmpSync_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // outputs from flip-flops; timerOut and the ready outputs through a gate
    assign timerOut = outLvl_q ^ pulse_q;
    assign timerOutEn = ctrl_q.outEn;
    assign reloadPulse = rel_q;
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready = !wHeld_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence seqMatchOneShot;
        reloadGo && ctrl_q.mode == MODE_ONESHOT;
    endsequence

    AST_RELOAD_VALUE: assert property (reloadGo && !(bvalid_d && !bvalid_q)
        |=> count_q == COUNT_RESTART)
        else $error("count not restarted at reload");
    AST_ONESHOT_STOP: assert property ((seqMatchOneShot and !(awHeld_q && wHeld_q))
        |=> !ctrl_q.enable)
        else $error("one-shot did not stop");
    AST_ONESHOT_PULSE: assert property (seqMatchOneShot |=> pulse_q ##1 !pulse_q)
        else $error("one-shot pulse not one cycle");
    AST_CONT_TOGGLE: assert property (reloadGo && ctrl_q.mode != MODE_ONESHOT
        |=> timerOut != $past(timerOut))
        else $error("output not toggled at reload");
    AST_MATCH_NEXT: assert property (reloadGo |=> reloadPulse)
        else $error("reload not one edge after match");
    AST_MATCH_CAUSE: assert property (match_q |-> $past(count_d) == count_q)
        else $error("match without count");
    AST_PRESCALE_GAP: assert property (ctrl_q.enable && !match_q && ctrl_q.mode == MODE_CONT
        && pre_q < ctrl_q.preMinus1 && !(awHeld_q && wHeld_q) |=> $stable(count_q))
        else $error("count moved between prescale ticks");
    AST_WRAP: assert property (ctrl_q.enable && count_q == 16'hFFFF && !match_q
        && reload_q != 16'h0000 && !(awHeld_q && wHeld_q) |=> count_q inside {16'hFFFF, 16'h0000})
        else $error("no rollover to zero");
    AST_COUNTER_STEP: assert property (ctrl_q.enable && !match_q && ctrl_q.mode == MODE_COUNTER
        && !(awHeld_q && wHeld_q) |=> count_q - $past(count_q) <= 16'h0001)
        else $error("counter stepped by more than one");
endmodule

// ---- shared/rltcm_pkg.sv ----
// Notes on behaviour
// - one-shot: reach reload, interrupt, 0001, stop
// - one-shot: output inverted one clock
// - timed modes count prescaled system clock
// - one-shot time is (reload-start) times prescale; the logic takes (reload-start+1) times prescale
// - continuous: reach reload, interrupt, 0001, continue
// - other modes toggle output at each reload
// - start count only for first pass
// - continuous period is reload times prescale
// - counter mode counts input pin edges
// - counter mode bypasses the prescaler
// - counter edge select sets initial output
// - comparator mode counts comparator edges, no prescale
// - counter modes reload to 0001 and resume
// - count minus start equals counted edges
// - FFFF without match rolls to 0000
// - prescale divides by 1 to 128
package rltcm_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] RELOAD_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    // control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_OUTEN_BIT = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_PRE_LSB = 8;
    // reset and reload values
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [6:0] PRE_RESET = 7'h00;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // timer modes
    typedef enum logic [1:0] {
        MODE_ONESHOT = 2'd0,
        MODE_CONT = 2'd1,
        MODE_COUNTER = 2'd2,
        MODE_CMPCNT = 2'd3
    } rltcm_mode_t;
    // control word as held
    typedef struct packed {
        logic [6:0] preMinus1; // divide = value + 1
        rltcm_mode_t mode;
        logic outEn;
        logic outputPolarityBit;
        logic enable;
    } rltcm_ctrl_t;
endpackage

// ---- testbench/rltcm_pin_src.sv ----
`timescale 1ns/1ps
module rltcm_pin_src (
    input wire logic sys_clk, // system clock
    input wire logic rstn, // reset, active low
    input wire logic start, // begin a burst of pulses
    input wire logic sel, // 0 pulses the timer input pin, 1 the comparator
    input wire logic idleLvl, // level between pulses
    input wire logic [7:0] nPulses, // pulses in one burst
    output logic done, // burst finished
    output logic timerInPin, // timer input pin level
    output logic cmpOut // comparator output level
);
    logic busy; // burst under way
    logic lvl; // level of the selected line
    logic other; // level of the unselected line
    logic [2:0] ph; // phase within one pulse
    logic [7:0] left; // pulses still to send
    ////////////////////////////////////////////////////////////////////////
    // one pulse every 8 clocks keeps the selected line under a quarter rate
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            lvl <= 1'b0;
            ph <= 3'h0;
            left <= 8'h00;
        end else if (start && !busy) begin
            busy <= 1'b1;
            left <= nPulses;
            ph <= 3'h0;
        end else if (busy) begin
            ph <= ph + 3'h1;
            // active half of the pulse holds the counted edge
            if (ph == 3'h3) begin
                lvl <= ~idleLvl;
            end
            if (ph == 3'h7) begin
                lvl <= idleLvl;
                left <= left - 8'h01;
                busy <= (left != 8'h01);
            end
        end else begin
            lvl <= idleLvl;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // the other line toggles at a quarter rate so a wrong source selection shows
    assign other = busy ? ph[1] : idleLvl;
    assign timerInPin = sel ? other : lvl;
    assign cmpOut = sel ? lvl : other;
    assign done = !busy;
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import rltcm_pkg::*;
    logic sys_clk, rstn; // clock and reset
    logic [7:0] awaddr, araddr, pN; // addresses, pulse count
    logic [31:0] wdata, rdata, rd; // write data, read data, last read
    logic awvalid, wvalid, bready, arvalid, rready; // master strobes
    logic awready, wready, bvalid, arready, rvalid; // slave strobes
    logic [1:0] bresp, rresp, rs; // responses, last response
    logic timerInPin, cmpOut, timerOut, timerOutEn, reloadPulse; // pins
    logic pStart, pSel, pIdle, pDone; // pin source control
    int fails, compares, cyc, seed, tB, div, rl, k, pre; // tallies and model state
    int pulseT[$]; // model record: cycle of each reload pulse
    logic outT[$]; // output level seen at each reload pulse
    int preList[3]; // prescale settings tried in continuous mode
    rltcm_timer u_rltcm_timer (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timerInPin(timerInPin), .cmpOut(cmpOut),
        .timerOut(timerOut), .timerOutEn(timerOutEn), .reloadPulse(reloadPulse));
    rltcm_pin_src u_rltcm_pin_src (.sys_clk(sys_clk), .rstn(rstn), .start(pStart),
        .sel(pSel), .idleLvl(pIdle), .nPulses(pN), .done(pDone),
        .timerInPin(timerInPin), .cmpOut(cmpOut));
    ////////////////////////////////////////////////////////////////////////
    // clock and pulse monitor, sampled mid-cycle where outputs are settled
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    always @(negedge sys_clk) begin
        if (reloadPulse === 1'b1) begin
            pulseT.push_back(cyc);
            outT.push_back(timerOut);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (e !== g) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // start-up of the prescaler phase is left open, so a small window is allowed
    task automatic chkNear(string nm, int e, int g);
        compares++;
        if (g < e - 2 || g > e + 5) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic tmo(string nm);
        fails++;
        $display("[ERR] %s expected answer seen timeout", nm);
        summarize();
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // one bus transfer; handshakes are judged at the negedge before the edge
    task automatic xfer(bit wr, logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int n;
        bit b, ta, tw, tr;
        b = 0;
        @(posedge sys_clk);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (n = 0; n < 50 && !b; n++) begin
            @(negedge sys_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            b = wr ? bvalid : rvalid;
            rs = wr ? bresp : rresp;
            rd = rdata;
            tB = cyc;
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (!b) tmo("bus");
        chk("resp", er, rs);
    endtask
    task automatic rdChk(string nm, logic [7:0] a, logic [31:0] e);
        xfer(0, a, 32'h0000_0000, AXI_OKAY);
        chk(nm, e, rd);
    endtask
    function automatic logic [31:0] cw(bit en, bit pol, rltcm_mode_t m, int p);
        return (32'(en) << CTRL_EN_BIT) | (32'(pol) << CTRL_POL_BIT) |
            (32'h0000_0001 << CTRL_OUTEN_BIT) | (32'(m) << CTRL_MODE_LSB) |
            (32'(p) << CTRL_PRE_LSB);
    endfunction
    // disable and configure, load count and reload, then enable
    task automatic cfg(rltcm_mode_t m, bit pol, int p, logic [15:0] st, logic [15:0] r);
        xfer(1, CTRL_OFS, cw(0, pol, m, p), AXI_OKAY);
        chk("timerOut initial", pol, timerOut);
        chk("timerOutEn", 1, timerOutEn);
        xfer(1, COUNT_OFS, st, AXI_OKAY);
        xfer(1, RELOAD_OFS, r, AXI_OKAY);
        xfer(1, CTRL_OFS, cw(1, pol, m, p), AXI_OKAY);
    endtask
    task automatic waitPulses(int n);
        int i;
        for (i = 0; i < 20000 && pulseT.size() < n; i++) @(negedge sys_clk);
        if (pulseT.size() < n) tmo("reloadPulse");
    endtask
    task automatic pins(int n);
        int i;
        @(posedge sys_clk);
        pN <= 8'(n);
        pStart <= 1'b1;
        @(posedge sys_clk);
        pStart <= 1'b0;
        @(negedge sys_clk);
        for (i = 0; i < 400 && pDone !== 1'b1; i++) @(negedge sys_clk);
        if (pDone !== 1'b1) tmo("pin source");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {fails, compares, cyc} = '0;
        seed = 32'h0000_0b2b;
        {awvalid, wvalid, bready, arvalid, rready, pStart, pSel, pIdle} = '0;
        {awaddr, araddr, pN, wdata} = '0;
        rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rdChk("ctrl reset", CTRL_OFS, 32'h0000_0000);
        rdChk("count reset", COUNT_OFS, 32'(COUNT_RESET));
        rdChk("reload reset", RELOAD_OFS, 32'(RELOAD_RESET));
        xfer(0, 8'h10, 32'h0000_0000, AXI_SLVERR);
        chk("unmapped rdata", 32'h0000_0000, rd);
        xfer(1, 8'h14, 32'h0000_0000, AXI_SLVERR);
        // one-shot starting near the top: the count rolls over before matching
        pre = $random(seed) & 3;
        cfg(MODE_ONESHOT, 1, pre, 16'hfff0, 16'h0004);
        waitPulses(1);
        chkNear("oneshot time", 20 * (pre + 1), pulseT[0] - tB);
        chk("oneshot pulse out", 0, outT[0]);
        @(negedge sys_clk);
        chk("oneshot out back", 1, timerOut);
        repeat (60) @(negedge sys_clk);
        chk("oneshot stopped", 1, pulseT.size());
        rdChk("oneshot count", COUNT_OFS, 32'(COUNT_RESTART));
        rdChk("oneshot ctrl", CTRL_OFS, cw(0, 1, MODE_ONESHOT, pre));
        rdChk("status", STATUS_OFS, 32'h0000_0003);
        xfer(1, STATUS_OFS, 32'h0000_0001, AXI_OKAY);
        rdChk("status cleared", STATUS_OFS, 32'h0000_0002);
        // continuous at both prescale ends and a random one, short first pass
        preList = '{0, 127, $random(seed) & 3};
        foreach (preList[j]) begin
            rl = 3 + ($random(seed) & 7);
            div = preList[j] + 1;
            k = pulseT.size();
            cfg(MODE_CONT, 0, preList[j], 16'(rl - 1), 16'(rl));
            waitPulses(k + 3);
            chk("period a", rl * div, pulseT[k + 1] - pulseT[k]);
            chk("period b", rl * div, pulseT[k + 2] - pulseT[k + 1]);
            chk("toggle a", 1, outT[k]);
            chk("toggle b", 0, outT[k + 1]);
            xfer(1, CTRL_OFS, cw(0, 0, MODE_CONT, preList[j]), AXI_OKAY);
        end
        // both counter modes, max prescale set to show it is bypassed
        for (int m = 2; m < 4; m++) begin
            pSel <= (m == 3);
            pIdle <= (m == 3);
            cfg(rltcm_mode_t'(m), m == 2, 127, 16'h0001, 16'h0005);
            k = pulseT.size();
            pins(3);
            repeat (8) @(negedge sys_clk);
            rdChk("edges counted", COUNT_OFS, 32'h0000_0004);
            pins(1);
            waitPulses(k + 1);
            chk("counter toggle", m == 3, outT[k]);
            rdChk("counter reload", COUNT_OFS, 32'(COUNT_RESTART));
            xfer(1, CTRL_OFS, cw(0, m == 2, rltcm_mode_t'(m), 127), AXI_OKAY);
        end
        summarize();
    end
endmodule
